/* File: cco_pkg.sv */
// ----------------------------------------------------------------------
// What this block does
// - Four cursor colour registers, indices zero to three.
// - Colours double buffered, active copy readable.
// - Read pixel and cursor word together.
// - Cursor hit from counters against position.
// - Clip partly visible cursor; hide disabled cursor.
// - Outside cursor, frame pixel passes unchanged.
// - Modes 000, 001, 010 are 2-bit modes.
// - 2-bit code picks colour or transformed frame.
// - Modes 011, 100 combine cursor word, frame.
// - 8-bit depth uses blue bytes only.
// - 16-bit depth uses low 5/6/5 bits.
// - Table of 256 entries, 10-bit RGB.
// - Blank windows or force bit zero output.
// - Border pixel uses border colour.
// - Lookup only while lookup enable set.
// - 24-bit lookup: each byte indexes own field.
// - 16-bit lookup: zero-extend 5/6/5 then map.
// - 8-bit lookup: blue indexes whole entry.
// - 24-bit no lookup: append two zeros.
// - 16-bit no lookup: append 5/4/5 zeros.
// - 8-bit no lookup: blue greyscale on all.
// - Position write arms; commit at vertical blank.
// - Line bytes 8/12/16 or 128/192/256.
// ----------------------------------------------------------------------
package cco_pkg;

  // ----------------------------------------------------------------------
  // Register word indexes (byte address is four times the index)
  // ----------------------------------------------------------------------
  localparam logic [9:0] A_CTRL = 10'h000;
  localparam logic [9:0] A_CUR_CTRL = 10'h001;
  localparam logic [9:0] A_CUR_POS = 10'h002;
  localparam logic [9:0] A_CUR_STAT = 10'h003;
  localparam logic [9:0] A_COLOR = 10'h004;
  localparam logic [9:0] A_COLOR_ACT = 10'h008;
  localparam logic [9:0] A_POS_ACT = 10'h00c;
  localparam logic [9:0] A_BORDER = 10'h00d;
  localparam logic [9:0] A_HBLANK = 10'h00e;
  localparam logic [9:0] A_VBLANK = 10'h00f;
  localparam logic [9:0] A_CODE_MAP = 10'h010;
  localparam logic [9:0] A_LUT = 10'h100;

  // ----------------------------------------------------------------------
  // Field positions and codes
  // ----------------------------------------------------------------------
  localparam int CTRL_LUT_EN = 0;
  localparam int CTRL_FBLANK = 1;
  localparam int CTRL_DEPTH = 2;
  localparam logic [1:0] DEPTH8 = 2'h0;
  localparam logic [1:0] DEPTH16 = 2'h1;
  localparam logic [1:0] DEPTH24 = 2'h2;
  localparam int CC_ENABLE = 3;
  localparam int CC_SIZE = 4;
  localparam int ST_ARMED = 8;
  localparam int ST_BYTES = 16;
  localparam logic [2:0] MODE_TWO = 3'h0;
  localparam logic [2:0] MODE_THREE = 3'h1;
  localparam logic [2:0] MODE_FOUR = 3'h2;
  localparam logic [2:0] MODE_RGB = 3'h3;
  localparam logic [2:0] MODE_MASKED = 3'h4;
  localparam logic [1:0] SIZE32 = 2'h0;
  localparam logic [1:0] SIZE48 = 2'h1;
  localparam logic [6:0] WIDTH32 = 7'h20;
  localparam logic [6:0] WIDTH48 = 7'h30;
  localparam logic [6:0] WIDTH64 = 7'h40;
  localparam int MAP_FRAME = 3;
  localparam int MAP_INVERT = 2;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [31:0] CTRL_RST = 32'h0000_0008;
  localparam logic [15:0] CODE_MAP_RST = 16'h10c8;

  typedef struct packed {
    logic [7:0] r;
    logic [7:0] g;
    logic [7:0] b;
  } cco_rgb24_type;

  typedef struct packed {
    logic [9:0] r;
    logic [9:0] g;
    logic [9:0] b;
  } cco_rgb30_type;

  typedef struct packed {
    logic border;
    logic [11:0] h;
    logic [11:0] v;
  } cco_timing_type;

endpackage

/* File: cco_overlay.sv */
`timescale 1ns/1ps
`default_nettype none

module cco_overlay (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic [9:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic pix_valid_i,
  input wire cco_pkg::cco_rgb24_type pix_i,
  input wire logic [31:0] cur_data_i,
  input wire cco_pkg::cco_timing_type tim_i,
  output cco_pkg::cco_rgb30_type pix_o,
  output logic pix_valid_o,
  output logic blank_o
);

  // ----------------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------------
  logic [31:0] ctrl;
  logic [5:0] cur_ctrl;
  logic [5:0] cur_ctrl_act;
  logic [31:0] pos;
  logic [31:0] pos_act;
  logic armed;
  logic [23:0] color [4];
  logic [23:0] color_act [4];
  logic [23:0] border_color;
  logic [31:0] hblank;
  logic [31:0] vblank;
  logic [15:0] code_map;
  cco_pkg::cco_rgb30_type lookup_table [256];
  logic rd_done;
  logic [31:0] next_rdata;
  logic [31:0] bmask;
  logic wr;
  logic vb_q;
  logic commit;

  assign bmask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                  {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
  assign wr = avs_write_i;

  // Reads wait one cycle so the wide table mux ends in a flip-flop.
  assign avs_waitrequest_o = avs_read_i & ~rd_done;

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rd_done <= 1'b0;
    end else begin
      rd_done <= avs_read_i & ~rd_done;
    end
  end

  // ----------------------------------------------------------------------
  // Software registers; cursor control and position are pending copies
  // ----------------------------------------------------------------------
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctrl <= cco_pkg::CTRL_RST;
      cur_ctrl <= 6'h0;
      pos <= 32'h0;
      border_color <= 24'h0;
      hblank <= 32'h0;
      vblank <= 32'h0;
      code_map <= cco_pkg::CODE_MAP_RST;
    end else if (wr) begin
      case (avs_address_i)
        cco_pkg::A_CTRL: begin
          ctrl <= (ctrl & ~bmask) | (avs_writedata_i & bmask);
        end
        cco_pkg::A_CUR_CTRL: begin
          if (avs_byteenable_i[0]) begin
            cur_ctrl <= avs_writedata_i[5:0];
          end
        end
        cco_pkg::A_CUR_POS: begin
          pos <= (pos & ~bmask) | (avs_writedata_i & bmask);
        end
        cco_pkg::A_BORDER: begin
          border_color <= 24'((({8'h0, border_color} & ~bmask)
                              | (avs_writedata_i & bmask)));
        end
        cco_pkg::A_HBLANK: begin
          hblank <= (hblank & ~bmask) | (avs_writedata_i & bmask);
        end
        cco_pkg::A_VBLANK: begin
          vblank <= (vblank & ~bmask) | (avs_writedata_i & bmask);
        end
        cco_pkg::A_CODE_MAP: begin
          code_map <= 16'((({16'h0, code_map} & ~bmask)
                          | (avs_writedata_i & bmask)));
        end
        default: begin
        end
      endcase
    end
  end

  // Colour pairs: software writes the pending copy, the pixel path only
  // ever sees the active copy, so a half-written colour never shows.
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_color
      always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
          color[gi] <= 24'h0;
        end else if (wr && avs_address_i == cco_pkg::A_COLOR + 10'(gi)) begin
          color[gi] <= 24'((({8'h0, color[gi]} & ~bmask)
                           | (avs_writedata_i & bmask)));
        end
      end
      always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
          color_act[gi] <= 24'h0;
        end else if (commit) begin
          color_act[gi] <= color[gi];
        end
      end
    end
  endgenerate

  // The table is plain storage with no reset; software loads it first.
  // table loaded by software
  always_ff @(posedge clock_i) begin
    if (wr && avs_address_i[9:8] == cco_pkg::A_LUT[9:8]) begin
      lookup_table[avs_address_i[7:0]] <= avs_writedata_i[29:0];
    end
  end

  // ----------------------------------------------------------------------
  // Update trigger and vertical blank commit
  // ----------------------------------------------------------------------
  logic hb;
  logic vb;
  logic blank;
  assign hb = tim_i.h >= hblank[11:0] && tim_i.h < hblank[27:16];
  assign vb = tim_i.v >= vblank[11:0] && tim_i.v < vblank[27:16];
  assign blank = ctrl[cco_pkg::CTRL_FBLANK] | hb | vb;
  assign commit = armed & vb & ~vb_q;

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      vb_q <= 1'b0;
    end else begin
      vb_q <= vb;
    end
  end

  // A new arm wins over the commit clear and over a cancel.
  // position write arms
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      armed <= 1'b0;
    end else if (wr && avs_address_i == cco_pkg::A_CUR_POS) begin
      armed <= 1'b1;
    end else if (commit) begin
      armed <= 1'b0;
    end else if (wr && avs_address_i == cco_pkg::A_CUR_STAT &&
                 avs_byteenable_i[1] && avs_writedata_i[cco_pkg::ST_ARMED]) begin
      armed <= 1'b0;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cur_ctrl_act <= 6'h0;
      pos_act <= 32'h0;
    end else if (commit) begin
      cur_ctrl_act <= cur_ctrl;
      pos_act <= pos;
    end
  end

  // ----------------------------------------------------------------------
  // Cursor geometry
  // ----------------------------------------------------------------------
  logic [2:0] act_mode;
  logic [6:0] width;
  logic [8:0] line_bytes;
  logic signed [16:0] dx;
  logic signed [16:0] dy;
  logic cursor_hit;
  assign act_mode = cur_ctrl_act[2:0];

  always_comb begin
    case (cur_ctrl_act[cco_pkg::CC_SIZE +: 2])
      cco_pkg::SIZE32: width = cco_pkg::WIDTH32;
      cco_pkg::SIZE48: width = cco_pkg::WIDTH48;
      default: width = cco_pkg::WIDTH64;
    endcase
  end

  // A 2-bit line is width/4 bytes, a 32-bit line is width*4 bytes.
  // bytes per line
  assign line_bytes = act_mode >= cco_pkg::MODE_RGB ?
                      {width, 2'h0} : {4'h0, width[6:2]};

  assign dx = $signed({5'h0, tim_i.h}) - $signed({pos_act[15], pos_act[15:0]});
  assign dy = $signed({5'h0, tim_i.v}) - $signed({pos_act[31], pos_act[31:16]});

  // Clipping falls out of showing the cursor only on active pixels.
  // hit and clip
  assign cursor_hit = cur_ctrl_act[cco_pkg::CC_ENABLE] &&
                      act_mode <= cco_pkg::MODE_MASKED &&
                      dx >= 0 && dx < $signed({10'h0, width}) &&
                      dy >= 0 && dy < $signed({10'h0, width}) &&
                      !blank && !tim_i.border;

  // ----------------------------------------------------------------------
  // Cursor mix
  // ----------------------------------------------------------------------
  function automatic logic [7:0] blend(input logic [7:0] c,
                                       input logic [7:0] f,
                                       input logic [7:0] a);
    logic [15:0] s;
    s = {8'h0, c} * {8'h0, a} + {8'h0, f} * {8'h0, 8'hff - a};
    return s[15:8];
  endfunction

  cco_pkg::cco_rgb24_type mix;
  logic [1:0] code;
  logic [3:0] sel;
  logic [7:0] alpha;
  assign code = cur_data_i[1:0];
  assign sel = code_map[{code, 2'h0} +: 4];
  assign alpha = cur_data_i[31:24];

  always_comb begin
    mix = pix_i;
    if (cursor_hit) begin
      case (act_mode)
        cco_pkg::MODE_TWO, cco_pkg::MODE_THREE, cco_pkg::MODE_FOUR: begin
          if (sel[cco_pkg::MAP_FRAME]) begin
            mix = pix_i ^ {24{sel[cco_pkg::MAP_INVERT]}};
          end else begin
            mix = color_act[sel[1:0]];
          end
        end
        cco_pkg::MODE_RGB: begin
          mix.r = blend(cur_data_i[23:16], pix_i.r, alpha);
          mix.g = blend(cur_data_i[15:8], pix_i.g, alpha);
          mix.b = blend(cur_data_i[7:0], pix_i.b, alpha);
        end
        cco_pkg::MODE_MASKED: begin
          if (alpha != 8'h0) begin
            mix = cur_data_i[23:0];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Border, blank and lookup stage
  // ----------------------------------------------------------------------
  cco_pkg::cco_rgb24_type item;
  cco_pkg::cco_rgb30_type next_pix;
  logic [1:0] depth;
  assign depth = ctrl[cco_pkg::CTRL_DEPTH +: 2];

  assign item = tim_i.border ? border_color : mix;

  always_comb begin
    next_pix = '0;
    if (ctrl[cco_pkg::CTRL_LUT_EN]) begin
      case (depth)
        cco_pkg::DEPTH8: begin
          next_pix = lookup_table[item.b];
        end
        cco_pkg::DEPTH16: begin
          next_pix.r = lookup_table[{3'h0, item.r[4:0]}].r;
          next_pix.g = lookup_table[{2'h0, item.g[5:0]}].g;
          next_pix.b = lookup_table[{3'h0, item.b[4:0]}].b;
        end
        default: begin
          next_pix.r = lookup_table[item.r].r;
          next_pix.g = lookup_table[item.g].g;
          next_pix.b = lookup_table[item.b].b;
        end
      endcase
    end else begin
      case (depth)
        cco_pkg::DEPTH8: begin
          next_pix = {3{item.b, 2'h0}};
        end
        cco_pkg::DEPTH16: begin
          next_pix = {item.r[4:0], 5'h0, item.g[5:0], 4'h0,
                      item.b[4:0], 5'h0};
        end
        default: begin
          next_pix = {item.r, 2'h0, item.g, 2'h0, item.b, 2'h0};
        end
      endcase
    end
    if (blank) begin
      next_pix = '0;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pix_o <= '0;
      pix_valid_o <= 1'b0;
      blank_o <= 1'b1;
    end else begin
      pix_o <= pix_valid_i ? next_pix : '0;
      pix_valid_o <= pix_valid_i;
      blank_o <= blank;
    end
  end

  // ----------------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------------
  always_comb begin
    next_rdata = 32'h0;
    if (avs_address_i[9:8] == cco_pkg::A_LUT[9:8]) begin
      next_rdata = {2'h0, lookup_table[avs_address_i[7:0]]};
    end else if (avs_address_i[9:2] == cco_pkg::A_COLOR[9:2]) begin
      next_rdata = {8'h0, color[avs_address_i[1:0]]};
    end else if (avs_address_i[9:2] == cco_pkg::A_COLOR_ACT[9:2]) begin
      next_rdata = {8'h0, color_act[avs_address_i[1:0]]};
    end else begin
      case (avs_address_i)
        cco_pkg::A_CTRL: next_rdata = ctrl;
        cco_pkg::A_CUR_CTRL: next_rdata = {26'h0, cur_ctrl};
        cco_pkg::A_CUR_POS: next_rdata = pos;
        cco_pkg::A_CUR_STAT: next_rdata = {7'h0, line_bytes, 7'h0, armed,
                                           2'h0, cur_ctrl_act};
        cco_pkg::A_POS_ACT: next_rdata = pos_act;
        cco_pkg::A_BORDER: next_rdata = {8'h0, border_color};
        cco_pkg::A_HBLANK: next_rdata = hblank;
        cco_pkg::A_VBLANK: next_rdata = vblank;
        cco_pkg::A_CODE_MAP: next_rdata = {16'h0, code_map};
        default: next_rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      avs_readdata_o <= 32'h0;
    end else if (avs_read_i && !rd_done) begin
      avs_readdata_o <= next_rdata;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);

  sequence s_arm;
    wr && avs_address_i == cco_pkg::A_CUR_POS;
  endsequence

  sequence s_commit;
    armed && vb && !vb_q;
  endsequence

  property p_arm;
    s_arm |=> armed;
  endproperty
  a_arm: assert property (p_arm) else $error("arm missing");

  property p_commit;
    s_commit ##0 !(wr && avs_address_i == cco_pkg::A_CUR_POS)
    |=> !armed && pos_act == $past(pos);
  endproperty
  a_commit: assert property (p_commit) else $error("commit bad");

  property p_color;
    commit |=> color_act[2] == $past(color[2]);
  endproperty
  a_color: assert property (p_color) else $error("colour copy");

  property p_blank;
    pix_valid_i && blank |=> pix_o == '0 && blank_o;
  endproperty
  a_blank: assert property (p_blank) else $error("not blank");

  property p_off_mode;
    act_mode > cco_pkg::MODE_MASKED |-> !cursor_hit;
  endproperty
  a_off_mode: assert property (p_off_mode) else $error("hidden");

  property p_pass;
    pix_valid_i && !cursor_hit && !blank && !tim_i.border &&
    !ctrl[cco_pkg::CTRL_LUT_EN] && depth == cco_pkg::DEPTH24
    |=> pix_o == {$past(pix_i.r), 2'h0, $past(pix_i.g), 2'h0,
                  $past(pix_i.b), 2'h0};
  endproperty
  a_pass: assert property (p_pass) else $error("frame altered");

  property p_grey;
    pix_valid_i && !ctrl[cco_pkg::CTRL_LUT_EN] && depth == cco_pkg::DEPTH8
    |=> pix_o.r == pix_o.g && pix_o.g == pix_o.b;
  endproperty
  a_grey: assert property (p_grey) else $error("not grey");

  property p_lut8;
    pix_valid_i && !blank && ctrl[cco_pkg::CTRL_LUT_EN] &&
    depth == cco_pkg::DEPTH8 |=> pix_o == $past(lookup_table[item.b]);
  endproperty
  a_lut8: assert property (p_lut8) else $error("lookup8");

  property p_read;
    avs_read_i && avs_waitrequest_o |=> !avs_waitrequest_o;
  endproperty
  a_read: assert property (p_read) else $error("read stall");

endmodule // cco_overlay

`default_nettype wire

/* File: cco_pix_peer.sv */
`timescale 1ns/1ps
`default_nettype none

// One-stage pixel and cursor register on the input side, output sink on the other.
module cco_pix_peer (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic req_i,
  input wire cco_pkg::cco_rgb24_type src_pix_i,
  input wire logic [31:0] src_cur_i,
  input wire cco_pkg::cco_timing_type src_tim_i,
  output cco_pkg::cco_rgb24_type pix_o,
  output logic [31:0] cur_o,
  output cco_pkg::cco_timing_type tim_o,
  output logic valid_o,
  input wire cco_pkg::cco_rgb30_type out_i,
  input wire logic out_valid_i,
  input wire logic out_blank_i,
  output cco_pkg::cco_rgb30_type got_o,
  output logic got_blank_o,
  output logic [15:0] got_cnt_o
);
  // pixel and cursor together
  // Idle cycles flip the data, so a stale word never passes for a pixel.
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      valid_o <= 1'b0;
      pix_o <= '0;
      cur_o <= '0;
      tim_o <= '0;
    end else if (req_i) begin
      valid_o <= 1'b1;
      pix_o <= src_pix_i;
      cur_o <= src_cur_i;
      tim_o <= src_tim_i;
    end else begin
      valid_o <= 1'b0;
      pix_o <= ~pix_o;
      cur_o <= ~cur_o;
    end
  end

  // The sink keeps the last qualified pixel and counts arrivals.
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      got_o <= '0;
      got_blank_o <= 1'b0;
      got_cnt_o <= 16'h0000;
    end else if (out_valid_i) begin
      got_o <= out_i;
      got_blank_o <= out_blank_i;
      got_cnt_o <= got_cnt_o + 16'h0001;
    end
  end
endmodule // cco_pix_peer

`default_nettype wire

/* File: tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic clock_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [9:0] avs_address_i = '0;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = '0;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic req = 1'b0;
  cco_pkg::cco_rgb24_type spix = '0;
  logic [31:0] scur = '0;
  cco_pkg::cco_timing_type stim = '0;
  cco_pkg::cco_rgb24_type f_pix;
  logic [31:0] f_cur;
  cco_pkg::cco_timing_type f_tim;
  logic f_valid;
  cco_pkg::cco_rgb30_type pix_o;
  logic pix_valid_o;
  logic blank_o;
  cco_pkg::cco_rgb30_type o;
  logic b;
  logic [15:0] got_cnt;
  int miscompares = 0;
  int checks_done = 0;
  logic [31:0] d;
  logic [3:0] n;
  cco_pkg::cco_rgb24_type pat = 24'h5a3c96;

  // Pixel clock, 8 ns period.
  initial begin
    forever #4 clock_i = ~clock_i;
  end

  cco_overlay uut (.clock_i(clock_i), .nrst_i(nrst_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_byteenable_i(4'hf),
    .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .pix_valid_i(f_valid),
    .pix_i(f_pix), .cur_data_i(f_cur), .tim_i(f_tim), .pix_o(pix_o),
    .pix_valid_o(pix_valid_o), .blank_o(blank_o));

  cco_pix_peer peer (.clock_i(clock_i), .nrst_i(nrst_i), .req_i(req),
    .src_pix_i(spix), .src_cur_i(scur), .src_tim_i(stim), .pix_o(f_pix),
    .cur_o(f_cur), .tim_o(f_tim), .valid_o(f_valid), .out_i(pix_o),
    .out_valid_i(pix_valid_o), .out_blank_i(blank_o), .got_o(o),
    .got_blank_o(b), .got_cnt_o(got_cnt));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [29:0] lv(input logic [7:0] i);
    return {i, 2'h1, ~i, 2'h2, i ^ 8'h5a, 2'h3};
  endfunction

  function automatic cco_pkg::cco_rgb24_type cc(input int i);
    return {8'h10 + 8'(i), 8'h80 + 8'(i), 8'hf0 - 8'(i)};
  endfunction

  function automatic cco_pkg::cco_timing_type t(input logic [11:0] h,
                                                input logic [11:0] v);
    return {1'b0, h, v};
  endfunction

  // Expected output word for a designated item at a depth and lookup mode.
  function automatic cco_pkg::cco_rgb30_type ex(
      input cco_pkg::cco_rgb24_type c, input logic [1:0] dp, input logic lu);
    logic [29:0] lr;
    logic [29:0] lg;
    logic [29:0] lb;
    lr = lv(c.r);
    lg = lv(c.g);
    lb = lv(c.b);
    if (dp == cco_pkg::DEPTH8) begin
      return lu ? lv(c.b) : {3{c.b, 2'h0}};
    end
    if (dp == cco_pkg::DEPTH16) begin
      lr = lv({3'h0, c.r[4:0]});
      lg = lv({2'h0, c.g[5:0]});
      lb = lv({3'h0, c.b[4:0]});
      if (!lu) begin
        return {c.r[4:0], 5'h0, c.g[5:0], 4'h0, c.b[4:0], 5'h0};
      end
    end
    if (lu) begin
      return {lr[29:20], lg[19:10], lb[9:0]};
    end
    return {c.r, 2'h0, c.g, 2'h0, c.b, 2'h0};
  endfunction

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Bus tasks hold the request until waitrequest is seen low at an edge.
  task automatic wr(input logic [9:0] a, input logic [31:0] v);
    avs_address_i <= a;
    avs_writedata_i <= v;
    avs_write_i <= 1'b1;
    do begin
      @(posedge clock_i);
    end while (avs_waitrequest_o !== 1'b0);
    avs_write_i <= 1'b0;
    @(posedge clock_i);
  endtask

  task automatic rd(input logic [9:0] a, output logic [31:0] v);
    avs_address_i <= a;
    avs_read_i <= 1'b1;
    do begin
      @(posedge clock_i);
    end while (avs_waitrequest_o !== 1'b0);
    v = avs_readdata_o;
    avs_read_i <= 1'b0;
    @(posedge clock_i);
  endtask

  // One pixel through the peer; waits a bounded time for it at the sink.
  task automatic px(input logic [31:0] c, input cco_pkg::cco_timing_type tm);
    int k;
    logic [15:0] c0;
    c0 = got_cnt;
    spix <= pat;
    scur <= c;
    stim <= tm;
    req <= 1'b1;
    @(posedge clock_i);
    req <= 1'b0;
    for (k = 0; k < 10 && got_cnt === c0; k++) begin
      @(posedge clock_i);
    end
    if (k == 10) begin
      chk("pixel_arrival", 32'h0, 32'h1);
    end
  endtask

  task automatic cpx(input logic [11:0] h, input logic [11:0] v,
                     input logic [31:0] c, input cco_pkg::cco_rgb24_type e);
    px(c, t(h, v));
    chk("cursor_pix", {2'h0, o}, {2'h0, ex(e, cco_pkg::DEPTH24, 1'b0)});
  endtask

  // A position write arms; a rising vertical window then commits.
  task automatic commit(input logic [31:0] ctl, input logic [31:0] pos);
    wr(cco_pkg::A_CUR_CTRL, ctl);
    wr(cco_pkg::A_CUR_POS, pos);
    rd(cco_pkg::A_CUR_STAT, d);
    chk("armed", {31'h0, d[cco_pkg::ST_ARMED]}, 32'h1);
    px(32'h0, t(12'h0, 12'h0));
    px(32'h0, t(12'h0, 12'h200));
    px(32'h0, t(12'h0, 12'h0));
  endtask

  task automatic results;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Cuts a hang short well beyond the expected run of about a thousand cycles.
  initial begin
    repeat (30000) @(posedge clock_i);
    miscompares++;
    results();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clock_i);
    nrst_i <= 1'b1;
    @(posedge clock_i);
    rd(cco_pkg::A_CTRL, d);
    chk("ctrl_reset", d, cco_pkg::CTRL_RST);
    wr(10'h0ff, 32'hffffffff);
    rd(10'h0ff, d);
    chk("unmapped", d, 32'h0);
    wr(cco_pkg::A_HBLANK, 32'h0900_0800);
    wr(cco_pkg::A_VBLANK, 32'h0210_0200);
    wr(cco_pkg::A_BORDER, 32'h00a1b2c3);
    for (int i = 0; i < 256; i++) begin
      wr(cco_pkg::A_LUT + 10'(i), {2'h0, lv(8'(i))});
    end
    rd(cco_pkg::A_LUT + 10'h34, d);
    chk("lut_read", d, {2'h0, lv(8'h34)});
    for (int lu = 0; lu < 2; lu++) begin
      for (int dp = 0; dp < 3; dp++) begin
        wr(cco_pkg::A_CTRL, {28'h0, 2'(dp), 1'b0, 1'(lu)});
        px(32'h2, t(12'h5, 12'h5));
        chk("colour", {2'h0, o}, {2'h0, ex(pat, 2'(dp), 1'(lu))});
        px(32'h2, {1'b1, 12'h6, 12'h5});
        chk("border", {2'h0, o}, {2'h0, ex(24'ha1b2c3, 2'(dp), 1'(lu))});
      end
    end
    wr(cco_pkg::A_CTRL, 32'h0000_000a);
    px(32'h0, t(12'h5, 12'h5));
    chk("force_blank", {1'b0, b, o}, 32'h4000_0000);
    wr(cco_pkg::A_CTRL, 32'h0000_0008);
    px(32'h0, t(12'h800, 12'h5));
    chk("h_blank", {1'b0, b, o}, 32'h4000_0000);
    px(32'h0, t(12'h900, 12'h5));
    chk("h_unblank", {1'b0, b, o}, {2'h0, ex(pat, 2'h2, 1'b0)});
    for (int i = 0; i < 4; i++) begin
      wr(cco_pkg::A_COLOR + 10'(i), {8'h0, cc(i)});
    end
    for (int m = 0; m < 3; m++) begin
      commit(32'h8 + 32'(m), {16'd20, 16'd10});
      for (int k = 0; k < 4; k++) begin
        n = cco_pkg::CODE_MAP_RST[k*4 +: 4];
        cpx(12'd10, 12'd20, 32'(k), n[3] ? (n[2] ?
          cco_pkg::cco_rgb24_type'(~pat) : pat) : cc(int'(n[1:0])));
      end
    end
    for (int i = 0; i < 4; i++) begin
      rd(cco_pkg::A_COLOR_ACT + 10'(i), d);
      chk("act_colour", d, {8'h0, cc(i)});
    end
    cpx(12'd41, 12'd51, 32'h2, cc(0));
    cpx(12'd42, 12'd20, 32'h2, pat);
    cpx(12'd9, 12'd20, 32'h2, pat);
    cpx(12'd10, 12'd52, 32'h2, pat);
    commit(32'h8, {16'd20, 16'hfffb});
    cpx(12'd0, 12'd20, 32'h2, cc(0));
    cpx(12'd26, 12'd20, 32'h2, cc(0));
    cpx(12'd27, 12'd20, 32'h2, pat);
    for (int s = 0; s < 3; s++) begin
      for (int r = 0; r < 2; r++) begin
        commit({26'h0, 2'(s), 1'b1, r ? 3'h3 : 3'h0}, {16'd20, 16'd10});
        rd(cco_pkg::A_CUR_STAT, d);
        chk("status", d, {7'h0, 9'((r ? 64 : 4) * (s + 2)), 7'h0, 1'b0,
          2'h0, 2'(s), 1'b1, r ? 3'h3 : 3'h0});
      end
    end
    // A cancelled update must not reach the active position at blank.
    wr(cco_pkg::A_CUR_POS, {16'd30, 16'd30});
    wr(cco_pkg::A_CUR_STAT, 32'h1 << cco_pkg::ST_ARMED);
    px(32'h0, t(12'h0, 12'h200));
    px(32'h0, t(12'h0, 12'h0));
    rd(cco_pkg::A_POS_ACT, d);
    chk("cancel", d, {16'd20, 16'd10});
    commit(32'hc, {16'd20, 16'd10});
    cpx(12'd10, 12'd20, 32'hff123456, 24'h123456);
    cpx(12'd10, 12'd20, 32'h00123456, pat);
    // Blend keeps 255/256 of one side at the alpha extremes.
    commit(32'hb, {16'd20, 16'd10});
    cpx(12'd10, 12'd20, 32'h00123456, 24'h593b95);
    cpx(12'd10, 12'd20, 32'hff123456, 24'h113355);
    commit(32'hd, {16'd20, 16'd10});
    cpx(12'd10, 12'd20, 32'h2, pat);
    commit(32'h0, {16'd20, 16'd10});
    cpx(12'd10, 12'd20, 32'h2, pat);
    results();
  end
endmodule // tb_top

`default_nettype wire
